// >>> hsmc_pkg.sv
// Package with constants, encodings and timing for the hall sensor mode control block.
package hsmc_pkg;

  // Core clock rate in kHz.
  localparam int unsigned CLK_KHZ = 25000;

  // Power-up and sleep-exit times in microseconds.
  localparam int unsigned T_POWER_UP_US = 270;
  localparam int unsigned T_SLEEP_EXIT_US = 50;
  // Cycle counts derived from the times.
  localparam int unsigned POWER_UP_CYC = (T_POWER_UP_US * CLK_KHZ) / 1000;
  localparam int unsigned SLEEP_EXIT_CYC = (T_SLEEP_EXIT_US * CLK_KHZ) / 1000;
  // Cycles in one millisecond, the tick of the doze interval timer.
  localparam int unsigned MS_CYC = CLK_KHZ;

  // Factory default target address options.
  localparam logic [6:0] ADDR_DEF_A = 7'h35;
  localparam logic [6:0] ADDR_DEF_B = 7'h22;
  localparam logic [6:0] ADDR_DEF_C = 7'h78;
  localparam logic [6:0] ADDR_DEF_D = 7'h44;

  // Operating-mode field encodings.
  localparam logic [1:0] OPM_STANDBY = 2'h0;
  localparam logic [1:0] OPM_SLEEP = 2'h1;
  localparam logic [1:0] OPM_CONT = 2'h2;
  localparam logic [1:0] OPM_WAKE_SLEEP = 2'h3;

  // Highest legal averaging code.
  localparam logic [2:0] AVG_MAX = 3'h5;

  // Register indices of the small control map.
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_MODE = 3'h1;
  localparam logic [2:0] REG_ADDR = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RESULT = 3'h4;

  // Bit positions inside the config register.
  localparam int unsigned CFG_XY_RANGE = 0;
  localparam int unsigned CFG_Z_RANGE = 1;
  localparam int unsigned CFG_AVG_LO = 2;
  localparam int unsigned CFG_CHN_LO = 5;

  // Mode machine states, one-hot.
  typedef enum logic [5:0] {
    HSMC_ST_OFF     = 6'h01,
    HSMC_ST_PWRUP   = 6'h02,
    HSMC_ST_STANDBY = 6'h04,
    HSMC_ST_SLEEP   = 6'h08,
    HSMC_ST_WAKING  = 6'h10,
    HSMC_ST_WS      = 6'h20
  } hsmc_state_t;

  // Convert an interval select code to one-ms ticks.
  function automatic logic [14:0] hsmc_doze_ms(input logic [3:0] sel);
    case (sel)
      4'h0: hsmc_doze_ms = 15'd1;
      4'h1: hsmc_doze_ms = 15'd5;
      4'h2: hsmc_doze_ms = 15'd10;
      4'h3: hsmc_doze_ms = 15'd15;
      4'h4: hsmc_doze_ms = 15'd20;
      4'h5: hsmc_doze_ms = 15'd30;
      4'h6: hsmc_doze_ms = 15'd50;
      4'h7: hsmc_doze_ms = 15'd100;
      4'h8: hsmc_doze_ms = 15'd500;
      4'h9: hsmc_doze_ms = 15'd1000;
      4'ha: hsmc_doze_ms = 15'd2000;
      4'hb: hsmc_doze_ms = 15'd5000;
      default: hsmc_doze_ms = 15'd20000;
    endcase
  endfunction

  // Conversion period in core cycles: the per-sample time grows with averaging and channel count.
  // Code 0 one axis is 50 us, each extra axis adds 25 us times the sample count of the code.
  function automatic logic [19:0] hsmc_conv_cyc(input logic [2:0] avg, input logic [1:0] nch);
    logic [19:0] samp;
    samp = 20'd1 << avg;
    hsmc_conv_cyc = 20'(((20'd25 + 20'd25 * samp * 20'(nch)) * 20'(CLK_KHZ / 1000)));
  endfunction

endpackage

// >>> hsmc_top.sv
// Operating-mode, address and range control for the hall sensor readout.
//
// Function
// - Default address set by ordered variant.
// - Written address becomes the new target address.
// - Separate range bits for XY and Z.
// - Averaging code 000b gives fastest rate.
// - Code 101b slowest; rate falls with code.
// - Mode field selects mode; start after supply.
// - First power-up ends in standby.
// - Standby converts on bus or pin trigger.
// - Standby keeps the last results.
// - Sleep keeps configuration, drops results.
// - Bus or pin wakes sleep to standby.
// - Bus wake pulses alert until standby reached.
// - Periodic mode wakes at selected interval.
// - Condition met: store results, go standby.
// - Condition unmet: keep periodic measuring.
// - Controller may wake periodic mode anytime.
// - No result interrupt in periodic mode.
// - Continuous mode keeps converting enabled channels.
// - Registers usable only in standby, continuous.
// - Asleep: wake on address, no acknowledge.
// - Sleep to standby takes about 50 us.
// - Power-up to standby takes about 270 us.
`timescale 1ns/1ps
`default_nettype none
module hsmc_top
  import hsmc_pkg::*;
#(
  parameter logic [6:0]  DEFAULT_ADDR  = ADDR_DEF_A,
  parameter int unsigned PWRUP_CYCLES  = POWER_UP_CYC,
  parameter int unsigned SLEEPX_CYCLES = SLEEP_EXIT_CYC,
  parameter int unsigned MS_CYCLES     = MS_CYC
) (
  input  wire logic        core_clk_i,      // Core clock, 25 MHz.
  input  wire logic        sys_rst_i,       // Asynchronous reset, active high.
  input  wire logic        supply_ok_i,     // Supply above minimum, asynchronous.
  input  wire logic        alert_n_i,       // Alert pin level, active low, asynchronous.
  input  wire logic        bus_addr_hit_i,  // Bus saw a start plus an address byte, one pulse.
  input  wire logic [6:0]  bus_addr_i,      // Address seen with the hit pulse.
  input  wire logic        bus_trig_i,      // Trigger bit of a bus command, one pulse.
  input  wire logic        conv_done_i,     // Front end finished a conversion, one pulse.
  input  wire logic        cond_met_i,      // Interrupt condition met by the last conversion.
  input  wire logic [15:0] conv_data_i,     // Conversion result from the front end.
  input  wire logic [2:0]  reg_addr_i,      // Register index.
  input  wire logic [7:0]  reg_wdata_i,     // Register write data.
  input  wire logic        reg_wr_i,        // Register write strobe.
  input  wire logic        reg_rd_i,        // Register read strobe.
  output logic      [7:0]  reg_rdata_o,     // Read data, one cycle after the strobe.
  output logic             addr_ack_o,      // Acknowledge of the address byte.
  output logic             conv_start_o,    // Start of one conversion, one pulse.
  output logic             alert_n_o,       // Alert pin drive value, active low.
  output logic             alert_oe_o,      // Alert pin output enable.
  output logic      [1:0]  range_sel_o,     // Bit 0 XY range, bit 1 Z range.
  output logic      [2:0]  sample_averaging_sel_o, // Averaging code in use.
  output logic      [1:0]  op_mode_o,       // Mode currently in effect.
  output logic             result_valid_o   // Result register holds a conversion.
);

  // Counts of zero, or counts that the 24-bit mode timer cannot hold, are refused here.
  if (PWRUP_CYCLES < 1 || SLEEPX_CYCLES < 1 || MS_CYCLES < 1 ||
      PWRUP_CYCLES > 24'hffffff || SLEEPX_CYCLES > 24'hffffff ||
      MS_CYCLES > 24'hffffff) begin : g_bad_timing
    $error("hsmc_top: timing counts out of range.");
  end

  // Whole state of the block.
  typedef struct packed {
    logic [1:0]  sup_s;       // Supply synchroniser.
    logic [1:0]  alt_s;       // Alert pin synchroniser.
    logic        alt_d;       // Previous synchronised alert level.
    hsmc_state_t st;          // Mode machine state.
    logic [1:0]  mode_fld;    // Operating-mode field.
    logic [3:0]  doze_interval_sel; // Periodic interval select.
    logic        xy_range;    // XY range select.
    logic        z_range;     // Z range select.
    logic [2:0]  avg;         // Averaging code.
    logic [1:0]  nch;         // Enabled magnetic channels, 1 to 3.
    logic [6:0]  taddr;       // Current target address.
    logic        addr_init;   // Target address loaded from the default.
    logic [15:0] result;      // Result register.
    logic        res_valid;   // Conversion-done flag.
    logic [23:0] tmr;         // Mode timing counter.
    logic [14:0] ms_cnt;      // Milliseconds elapsed while dozing.
    logic [19:0] conv_tmr;    // Continuous mode conversion spacing.
    logic        bus_wake;    // Current wake came from the bus.
    logic [7:0]  rdata;       // Read data register.
    logic        ack;         // Address acknowledge.
    logic        start;       // Conversion start pulse.
    logic        alert_n;     // Alert drive value.
    logic        alert_oe;    // Alert drive enable.
  } hsmc_regs_t;

  hsmc_regs_t cur_r;
  hsmc_regs_t cur_nxt;

  // Helper decodes from the current state.
  logic alert_fall;
  logic reg_ok;
  logic addr_match;
  logic conv_due;
  assign alert_fall = cur_r.alt_d & ~cur_r.alt_s[1];
  // Registers answer only in standby or continuous mode.
  assign reg_ok = (cur_r.st == HSMC_ST_STANDBY);
  assign addr_match = bus_addr_hit_i && (bus_addr_i == cur_r.taddr);
  assign conv_due = (cur_r.conv_tmr == 20'd0);

  // Next state logic for the whole block.
  always_comb begin
    cur_nxt = cur_r;
    cur_nxt.sup_s = {cur_r.sup_s[0], supply_ok_i};
    cur_nxt.alt_s = {cur_r.alt_s[0], alert_n_i};
    cur_nxt.alt_d = cur_r.alt_s[1];
    cur_nxt.ack = 1'b0;
    cur_nxt.start = 1'b0;
    cur_nxt.rdata = 8'h00;
    // The default address is taken once, after reset, not under the reset itself.
    if (!cur_r.addr_init) begin
      cur_nxt.taddr = DEFAULT_ADDR;
      cur_nxt.addr_init = 1'b1;
    end

    case (cur_r.st)
      HSMC_ST_OFF: begin
        // Nothing happens until the supply is good.
        if (cur_r.sup_s[1]) begin
          cur_nxt.st = HSMC_ST_PWRUP;
          cur_nxt.tmr = 24'(PWRUP_CYCLES - 1);
        end
      end
      HSMC_ST_PWRUP: begin
        if (cur_r.tmr == 24'd0) begin
          cur_nxt.st = HSMC_ST_STANDBY;
        end else begin
          cur_nxt.tmr = cur_r.tmr - 24'd1;
        end
      end
      HSMC_ST_STANDBY: begin
        // Standby and continuous share this state; the mode field picks the behaviour.
        cur_nxt.ack = addr_match;
        if (cur_r.mode_fld == OPM_CONT) begin
          // Free running conversions at the averaging-dependent rate.
          if (conv_due) begin
            cur_nxt.start = 1'b1;
            cur_nxt.conv_tmr = hsmc_conv_cyc(cur_r.avg, cur_r.nch) - 20'd1;
          end else begin
            cur_nxt.conv_tmr = cur_r.conv_tmr - 20'd1;
          end
        end else if (bus_trig_i || alert_fall) begin
          cur_nxt.start = 1'b1;
        end
        // A completed conversion updates results; otherwise they hold.
        if (conv_done_i) begin
          cur_nxt.result = conv_data_i;
          cur_nxt.res_valid = 1'b1;
        end
      end
      HSMC_ST_SLEEP: begin
        // Results are dropped in sleep, configuration stays.
        cur_nxt.res_valid = 1'b0;
        cur_nxt.result = 16'h0000;
        if (addr_match || alert_fall) begin
          // Wake without acknowledging the address.
          cur_nxt.st = HSMC_ST_WAKING;
          cur_nxt.tmr = 24'(SLEEPX_CYCLES - 1);
          cur_nxt.bus_wake = addr_match;
          cur_nxt.alert_n = ~addr_match;
          cur_nxt.alert_oe = addr_match;
        end
      end
      HSMC_ST_WAKING: begin
        cur_nxt.res_valid = 1'b0;
        if (cur_r.tmr == 24'd0) begin
          cur_nxt.st = HSMC_ST_STANDBY;
          cur_nxt.mode_fld = OPM_STANDBY;
          cur_nxt.alert_n = 1'b1;
          cur_nxt.alert_oe = 1'b0;
          cur_nxt.bus_wake = 1'b0;
        end else begin
          cur_nxt.tmr = cur_r.tmr - 24'd1;
        end
      end
      HSMC_ST_WS: begin
        // Periodic wake and measure; no result interrupt here.
        if (addr_match || alert_fall) begin
          cur_nxt.st = HSMC_ST_WAKING;
          cur_nxt.tmr = 24'(SLEEPX_CYCLES - 1);
          cur_nxt.bus_wake = addr_match;
          cur_nxt.alert_n = ~addr_match;
          cur_nxt.alert_oe = addr_match;
        end else if (conv_done_i) begin
          if (cond_met_i) begin
            cur_nxt.result = conv_data_i;
            cur_nxt.res_valid = 1'b1;
            cur_nxt.st = HSMC_ST_STANDBY;
            cur_nxt.mode_fld = OPM_STANDBY;
          end
          // Unmet condition keeps the periodic loop going.
        end else if (cur_r.tmr == 24'(MS_CYCLES - 1)) begin
          cur_nxt.tmr = 24'd0;
          if (cur_r.ms_cnt + 15'd1 >= hsmc_doze_ms(cur_r.doze_interval_sel)) begin
            cur_nxt.ms_cnt = 15'd0;
            cur_nxt.start = 1'b1;
          end else begin
            cur_nxt.ms_cnt = cur_r.ms_cnt + 15'd1;
          end
        end else begin
          cur_nxt.tmr = cur_r.tmr + 24'd1;
        end
      end
      default: cur_nxt.st = HSMC_ST_OFF;
    endcase

    // Register access, only while awake.
    if (reg_ok && reg_wr_i) begin
      case (reg_addr_i)
        REG_CFG: begin
          cur_nxt.xy_range = reg_wdata_i[CFG_XY_RANGE];
          cur_nxt.z_range = reg_wdata_i[CFG_Z_RANGE];
          if (reg_wdata_i[CFG_AVG_LO +: 3] <= AVG_MAX)
            cur_nxt.avg = reg_wdata_i[CFG_AVG_LO +: 3];
          if (reg_wdata_i[CFG_CHN_LO +: 2] != 2'h0)
            cur_nxt.nch = reg_wdata_i[CFG_CHN_LO +: 2];
        end
        REG_MODE: begin
          // Mode selects from the written field.
          cur_nxt.mode_fld = reg_wdata_i[1:0];
          cur_nxt.doze_interval_sel = reg_wdata_i[7:4];
          cur_nxt.conv_tmr = 20'd0;
          if (reg_wdata_i[1:0] == OPM_SLEEP) begin
            cur_nxt.st = HSMC_ST_SLEEP;
          end else if (reg_wdata_i[1:0] == OPM_WAKE_SLEEP) begin
            cur_nxt.st = HSMC_ST_WS;
            cur_nxt.tmr = 24'd0;
            cur_nxt.ms_cnt = 15'd0;
          end
        end
        REG_ADDR: cur_nxt.taddr = reg_wdata_i[6:0];
        default: ;
      endcase
    end
    if (reg_ok && reg_rd_i) begin
      case (reg_addr_i)
        REG_CFG: cur_nxt.rdata = {1'b0, cur_r.nch, cur_r.avg, cur_r.z_range, cur_r.xy_range};
        REG_MODE: cur_nxt.rdata = {cur_r.doze_interval_sel, 2'h0, cur_r.mode_fld};
        REG_ADDR: cur_nxt.rdata = {1'b0, cur_r.taddr};
        REG_STATUS: cur_nxt.rdata = {cur_r.res_valid, 1'b0, cur_r.st};
        REG_RESULT: cur_nxt.rdata = cur_r.result[7:0];
        default: cur_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cur_r <= '{sup_s: 2'h0, alt_s: 2'h3, alt_d: 1'b1, st: HSMC_ST_OFF,
                 mode_fld: OPM_STANDBY, doze_interval_sel: 4'h0, xy_range: 1'b0,
                 z_range: 1'b0, avg: 3'h0, nch: 2'h1, taddr: 7'h00, addr_init: 1'b0,
                 result: 16'h0000, res_valid: 1'b0, tmr: 24'h000000, ms_cnt: 15'h0000,
                 conv_tmr: 20'h00000, bus_wake: 1'b0, rdata: 8'h00, ack: 1'b0,
                 start: 1'b0, alert_n: 1'b1, alert_oe: 1'b0};
    end else begin
      cur_r <= cur_nxt;
    end
  end

  // Outputs straight from the state flops.
  assign reg_rdata_o = cur_r.rdata;
  assign addr_ack_o = cur_r.ack;
  assign conv_start_o = cur_r.start;
  assign alert_n_o = cur_r.alert_n;
  assign alert_oe_o = cur_r.alert_oe;
  assign range_sel_o = {cur_r.z_range, cur_r.xy_range};
  assign sample_averaging_sel_o = cur_r.avg;
  assign op_mode_o = cur_r.mode_fld;
  assign result_valid_o = cur_r.res_valid;

endmodule
`default_nettype wire

// >>> hsmc_checker.sv
// Concurrent checks of the mode, wake and register rules at the block ports.
`timescale 1ns/1ps
`default_nettype none
module hsmc_checker
  import hsmc_pkg::*;
#(
  parameter int unsigned SLEEPX_CYCLES = SLEEP_EXIT_CYC
) (
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       bus_addr_hit_i,
  input wire logic       conv_done_i,
  input wire logic       cond_met_i,
  input wire logic       alert_n_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       addr_ack_o,
  input wire logic       alert_n_o,
  input wire logic       alert_oe_o,
  input wire logic [1:0] op_mode_o,
  input wire logic       result_valid_o
);
  // Longest bus wake, with margin for the pin synchroniser.
  localparam int WAKE_MAX = SLEEPX_CYCLES + 8;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A bus wake ends in standby with the alert line let go.
  sequence s_wake_end;
    ##[1:WAKE_MAX] (!alert_oe_o && op_mode_o == OPM_STANDBY);
  endsequence
  // A periodic conversion that meets the condition.
  sequence s_ws_hit;
    op_mode_o == OPM_WAKE_SLEEP && conv_done_i && cond_met_i;
  endsequence
  ack_hit_a: assert property (addr_ack_o |-> $past(bus_addr_hit_i))
    else $error("ack without address phase");
  sleep_noack_a: assert property ((bus_addr_hit_i && op_mode_o == OPM_SLEEP) |=> !addr_ack_o)
    else $error("ack while asleep");
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside read slot");
  rd_refuse_a: assert property ((reg_rd_i && op_mode_o == OPM_SLEEP) |=> reg_rdata_o == 8'h00)
    else $error("read served while asleep");
  drop_res_a: assert property ((op_mode_o == OPM_SLEEP && $past(op_mode_o) == OPM_SLEEP) |-> !result_valid_o)
    else $error("result kept in sleep");
  alert_low_a: assert property (alert_oe_o |-> !alert_n_o)
    else $error("alert enabled but not low");
  wake_end_a: assert property ($rose(alert_oe_o) |-> s_wake_end)
    else $error("bus wake did not reach standby");
  wake_hold_a: assert property ($rose(alert_oe_o) |-> alert_oe_o[*4])
    else $error("wake alert too short");
  ws_exit_a: assert property (s_ws_hit |-> ##[1:3] (op_mode_o == OPM_STANDBY && result_valid_o))
    else $error("periodic hit did not stop in standby");
  ws_stay_a: assert property ((op_mode_o == OPM_WAKE_SLEEP && conv_done_i && !cond_met_i && alert_n_i
      && !bus_addr_hit_i) |=> op_mode_o == OPM_WAKE_SLEEP)
    else $error("periodic mode left without cause");
  ws_noint_a: assert property ((op_mode_o == OPM_WAKE_SLEEP && conv_done_i && !bus_addr_hit_i) |=> !$rose(alert_oe_o))
    else $error("result interrupt in periodic mode");
endmodule
bind hsmc_top hsmc_checker #(.SLEEPX_CYCLES(SLEEPX_CYCLES)) hsmc_checker_inst (
  .core_clk_i     (core_clk_i),
  .sys_rst_i      (sys_rst_i),
  .bus_addr_hit_i (bus_addr_hit_i),
  .conv_done_i    (conv_done_i),
  .cond_met_i     (cond_met_i),
  .alert_n_i      (alert_n_i),
  .reg_rd_i       (reg_rd_i),
  .reg_rdata_o    (reg_rdata_o),
  .addr_ack_o     (addr_ack_o),
  .alert_n_o      (alert_n_o),
  .alert_oe_o     (alert_oe_o),
  .op_mode_o      (op_mode_o),
  .result_valid_o (result_valid_o)
);
`default_nettype wire

// >>> hsmc_ctrl_model.sv
// Bus controller model: address phases and the shared open-drain alert line.
`timescale 1ns/1ps
`default_nettype none
module hsmc_ctrl_model (
  input  wire logic       core_clk_i, // Core clock.
  input  wire logic       send_i,     // Request one address phase.
  input  wire logic [6:0] addr_i,     // Address to send.
  input  wire logic       pull_i,     // Controller pulls the alert line low.
  input  wire logic       dev_n_i,    // Device alert drive value.
  input  wire logic       dev_oe_i,   // Device alert drive enable.
  output logic            hit_o = 1'b0,
  output logic      [6:0] addr_o = 7'h00,
  output logic            alert_o
);
  // Pull-up wins unless a party pulls low; a device enable pulls low only with a low drive value.
  assign alert_o = !(pull_i || (dev_oe_i && !dev_n_i));
  // One address phase per request; the idle address toggles so stale values never match.
  always @(posedge core_clk_i) begin
    hit_o <= send_i;
    addr_o <= send_i ? addr_i : ~addr_o;
  end
endmodule
`default_nettype wire

// >>> test_hall_sensor_mode_control.sv
// Self-checking bench of the hall sensor mode control block.
`timescale 1ns/1ps
`default_nettype none
module test_hall_sensor_mode_control;
  import hsmc_pkg::*;
  logic core_clk_i, sys_rst_i, bus_trig_i, conv_done_i, cond_met_i, reg_wr_i, reg_rd_i;
  logic send, pull, hit, alert_line, supply, addr_ack_o, conv_start_o, alert_n_o;
  logic alert_oe_o, result_valid_o;
  logic [15:0] conv_data_i;
  logic [2:0]  reg_addr_i, sample_averaging_sel_o;
  logic [7:0]  reg_wdata_i, reg_rdata_o, d;
  logic [6:0]  send_addr, baddr;
  logic [1:0]  range_sel_o, op_mode_o;
  int          checks, fail_count, n;
  int          lo_cnt = 0; // Cycles seen with the alert line low.
  int          lo_base;    // Snapshot of lo_cnt before a wake.
  // Short counts keep waits brief; expectations below follow these values.
  hsmc_top #(.PWRUP_CYCLES(10), .SLEEPX_CYCLES(5), .MS_CYCLES(4)) hsmc_top_inst (.*,
    .supply_ok_i(supply), .alert_n_i(alert_line), .bus_addr_hit_i(hit), .bus_addr_i(baddr));
  hsmc_ctrl_model hsmc_ctrl_model_inst (.core_clk_i, .send_i(send), .addr_i(send_addr),
    .pull_i(pull), .dev_n_i(alert_n_o), .dev_oe_i(alert_oe_o), .hit_o(hit), .addr_o(baddr),
    .alert_o(alert_line));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  // Count low cycles of the alert line; only this process writes the counter.
  always @(posedge core_clk_i) lo_cnt <= lo_cnt + int'(!alert_line);
  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic tmo;
    fail_count++;
    $display("BAD wait ran out");
    test_done;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic rdc(input string s, input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk(s, 16'(d), 16'(e));
  endtask
  // Polls status until the standby bit shows; refused reads return zero meanwhile.
  task automatic wait_ready;
    n = 0;
    d = 8'h00;
    while (d[2] !== 1'b1 && n < 40) begin
      rd(REG_STATUS);
      n++;
    end
    if (d[2] !== 1'b1) tmo;
  endtask
  task automatic wait_start(input int lim);
    n = 0;
    #1;
    while (conv_start_o !== 1'b1 && n < lim) begin
      @(posedge core_clk_i);
      #1 n++;
    end
    if (conv_start_o !== 1'b1) tmo;
  endtask
  task automatic conv(input logic c, input logic [15:0] v);
    @(posedge core_clk_i);
    conv_done_i <= 1'b1;
    cond_met_i <= c;
    conv_data_i <= v;
    @(posedge core_clk_i);
    conv_done_i <= 1'b0;
    conv_data_i <= ~v;
    tick(2);
  endtask
  task automatic addr_try(input logic [6:0] a, input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge core_clk_i);
    send <= 1'b1;
    send_addr <= a;
    @(posedge core_clk_i);
    send <= 1'b0;
    repeat (4) begin
      @(posedge core_clk_i);
      #1 seen |= addr_ack_o;
    end
    chk("ack", 16'(seen), 16'(e));
  endtask
  task automatic pull_alert;
    @(posedge core_clk_i);
    pull <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    pull <= 1'b0;
  endtask
  task automatic t_power;
    tick(1);
    chk("alert idle", 16'(alert_n_o), 16'h1);
    // Supply still low: far past the short power-up count, yet no standby.
    tick(30);
    rdc("no supply", REG_STATUS, 8'h00);
    @(posedge core_clk_i);
    supply <= 1'b1;
    rdc("early status", REG_STATUS, 8'h00);
    wait_ready;
    chk("first status", 16'(d), 16'h04);
    $display("test power done");
  endtask
  task automatic t_addr;
    addr_try(ADDR_DEF_A, 1'b1);
    addr_try(7'h22, 1'b0);
    wr(REG_ADDR, 8'h12);
    addr_try(ADDR_DEF_A, 1'b0);
    addr_try(7'h12, 1'b1);
    $display("test addr done");
  endtask
  task automatic t_cfg;
    rdc("cfg reset", REG_CFG, 8'h20);
    wr(REG_CFG, 8'h35);
    tick(1);
    chk("range", 16'(range_sel_o), 16'h1);
    chk("avg slow", 16'(sample_averaging_sel_o), 16'h5);
    wr(REG_CFG, 8'h39);
    tick(1);
    chk("avg bad", 16'(sample_averaging_sel_o), 16'h5);
    wr(REG_CFG, 8'h22);
    tick(1);
    chk("range z", 16'(range_sel_o), 16'h2);
    chk("avg fast", 16'(sample_averaging_sel_o), 16'h0);
    $display("test cfg done");
  endtask
  task automatic t_standby;
    fork
      begin
        @(posedge core_clk_i);
        bus_trig_i <= 1'b1;
        @(posedge core_clk_i);
        bus_trig_i <= 1'b0;
      end
      wait_start(6);
    join
    conv(1'b0, 16'h5aa5);
    chk("valid", 16'(result_valid_o), 16'h1);
    fork
      pull_alert;
      wait_start(10);
    join
    conv(1'b0, 16'h0033);
    tick(20);
    rdc("kept", REG_RESULT, 8'h33);
    $display("test standby done");
  endtask
  task automatic t_sleep;
    wr(REG_MODE, 8'h01);
    tick(2);
    chk("mode", 16'(op_mode_o), 16'(OPM_SLEEP));
    chk("dropped", 16'(result_valid_o), 16'h0);
    rdc("refused", REG_CFG, 8'h00);
    lo_base = lo_cnt;
    addr_try(7'h12, 1'b0);
    wait_ready;
    chk("wake alert", 16'(lo_cnt != lo_base), 16'h1);
    chk("wake valid", 16'(result_valid_o), 16'h0);
    chk("wake oe", 16'(alert_oe_o), 16'h0);
    rdc("cfg kept", REG_CFG, 8'h22);
    wr(REG_MODE, 8'h01);
    pull_alert;
    wait_ready;
    chk("pin wake", 16'(op_mode_o), 16'(OPM_STANDBY));
    $display("test sleep done");
  endtask
  task automatic t_ws;
    wr(REG_MODE, 8'h03);
    wait_start(12);
    conv(1'b0, 16'h1111);
    chk("ws stay", 16'(op_mode_o), 16'(OPM_WAKE_SLEEP));
    wait_start(12);
    conv(1'b1, 16'h0077);
    chk("ws exit", 16'(op_mode_o), 16'(OPM_STANDBY));
    rdc("ws result", REG_RESULT, 8'h77);
    wr(REG_MODE, 8'h13);
    wait_start(40);
    @(posedge core_clk_i);
    wait_start(40);
    chk("ws period", 16'(n + 1), 16'd20);
    lo_base = lo_cnt;
    addr_try(7'h12, 1'b0);
    wait_ready;
    chk("ws bus wake", 16'(lo_cnt != lo_base), 16'h1);
    wr(REG_MODE, 8'h03);
    pull_alert;
    wait_ready;
    chk("ws pin wake", 16'(op_mode_o), 16'(OPM_STANDBY));
    $display("test ws done");
  endtask
  task automatic t_cont;
    wr(REG_MODE, 8'h02);
    wait_start(1300);
    @(posedge core_clk_i);
    wait_start(1300);
    chk("cont period", 16'(n + 1), 16'd1250);
    conv(1'b0, 16'h00c3);
    rdc("cont result", REG_RESULT, 8'hc3);
    rdc("cont status", REG_STATUS, 8'h84);
    wr(REG_MODE, 8'h00);
    $display("test cont done");
  endtask
  initial begin
    {sys_rst_i, bus_trig_i, conv_done_i, cond_met_i, reg_wr_i, reg_rd_i} = 6'h20;
    {send, pull, supply, conv_data_i, reg_addr_i, reg_wdata_i, send_addr} = '0;
    {checks, fail_count} = '0;
    repeat (12) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_power;
    t_addr;
    t_cfg;
    t_standby;
    t_sleep;
    t_ws;
    t_cont;
    test_done;
  end
endmodule
`default_nettype wire
